// *** shared/gsd_map.svh ***
// gain strap decoder constants
`ifndef GSD_MAP_SVH
`define GSD_MAP_SVH
`define GSD_CODE_LOW 2'h0
`define GSD_CODE_MID 2'h1
`define GSD_CODE_HIGH 2'h2
`define GSD_CODE_SW 2'h3
// analog gain codes, in tenths of a dBV
`define GSD_ANA_LOW 9'h0c0
`define GSD_ANA_MID 9'h0e2
`define GSD_ANA_HIGH 9'h0fa
// digital boost, in whole dB
`define GSD_BOOST_DB 5'h06
// volume, in whole dB, reset value
`define GSD_VOL_RESET 8'h00
// switching frequency multiples of sample rate
`define GSD_FSW_LOW_MULT 5'h10
`define GSD_FSW_HIGH_MULT 5'h08
`endif

// *** shared/gsd_pkg.sv ***
// gain strap decoder types
package gsd_pkg;
  typedef enum logic [1:0] {
    GSD_ST_RESET,
    GSD_ST_SETTLE,
    GSD_ST_LATCHED
  } gsd_state_t;
endpackage : gsd_pkg

// *** src/gsd_sync.sv ***
// two-flop synchroniser for a group of bits
`timescale 1ns/1ps
module gsd_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_out = sync_r;
endmodule : gsd_sync

// *** src/gsd_decoder.sv ***
// gain strap and control mode decoder
//
// Summary of operation
// - in hardware mode the amplifier gain comes from the two-bit gain strap.
// - gain strap 11 puts the device into software control mode.
// - digital volume resets to 0 dB and stays there in hardware mode.
// - digital boost is held at +6 dB for every hardware gain strap code.
// - analog gain is 19.2 dBV for 00, 22.6 dBV for 01 and 25 dBV for 10.
// - in software mode analog and digital gain come from the control port settings.
// - in software mode the bridge strap pin is the control clock and the frequency pin the control data.
// - in hardware mode switching frequency is 16 fs with frequency strap low and 8 fs when high.
// - in hardware mode bridge strap high selects parallel bridge and low normal bridge.
`timescale 1ns/1ps
`include "gsd_map.svh"
module gsd_decoder #(
  parameter int SETTLE_CYCLES = 4
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // board straps
  input wire logic gain_strap_hi_in,
  input wire logic gain_strap_lo_in,
  input wire logic bridge_mode_clock_pin_in,
  input wire logic switch_freq_data_pin_in,
  // control port settings for software mode
  input wire logic [8:0] sw_analog_gain_in,
  input wire logic [4:0] sw_boost_in,
  input wire logic [7:0] sw_volume_in,
  input wire logic sw_parallel_bridge_in,
  input wire logic [4:0] sw_fsw_mult_in,
  // control port pins
  output logic ctrl_scl_out,
  output logic ctrl_sda_out,
  // decoded configuration
  output logic sw_mode_out,
  output logic config_valid_out,
  output logic [1:0] gain_strap_out,
  output logic [8:0] analog_path_gain_out,
  output logic [4:0] digital_path_gain_out,
  output logic [7:0] volume_out,
  output logic parallel_bridge_mode_out,
  output logic [4:0] fsw_mult_out
);
  // ---------------------------------------------------------------
  // strap synchroniser
  // ---------------------------------------------------------------
  logic [3:0] strap_sync;

  gsd_sync #(
    .WIDTH(4)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({gain_strap_hi_in, gain_strap_lo_in, bridge_mode_clock_pin_in, switch_freq_data_pin_in}),
    .q_out(strap_sync)
  );

  // ---------------------------------------------------------------
  // latch sequencer
  // ---------------------------------------------------------------
  gsd_pkg::gsd_state_t state_r;
  gsd_pkg::gsd_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [1:0] gain_r;
  logic [1:0] gain_nxt;
  logic bridge_r;
  logic bridge_nxt;
  logic freq_r;
  logic freq_nxt;
  logic valid_r;
  logic valid_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    gain_nxt = gain_r;
    bridge_nxt = bridge_r;
    freq_nxt = freq_r;
    valid_nxt = valid_r;
    case (state_r)
      gsd_pkg::GSD_ST_RESET:
      begin
        cnt_nxt = 8'h00;
        state_nxt = gsd_pkg::GSD_ST_SETTLE;
      end
      gsd_pkg::GSD_ST_SETTLE:
      begin
        // wait for synchroniser to fill
        if (cnt_r >= 8'(SETTLE_CYCLES - 1))
        begin
          gain_nxt = strap_sync[3:2];
          bridge_nxt = strap_sync[1];
          freq_nxt = strap_sync[0];
          valid_nxt = 1'b1;
          state_nxt = gsd_pkg::GSD_ST_LATCHED;
        end
        else
        begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      gsd_pkg::GSD_ST_LATCHED:
      begin
        // hold configuration until next reset
        state_nxt = gsd_pkg::GSD_ST_LATCHED;
      end
      default:
      begin
        state_nxt = gsd_pkg::GSD_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= gsd_pkg::GSD_ST_RESET;
      cnt_r <= 8'h00;
      gain_r <= 2'h0;
      bridge_r <= 1'b0;
      freq_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      gain_r <= gain_nxt;
      bridge_r <= bridge_nxt;
      freq_r <= freq_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  logic sw_mode;
  logic [8:0] ana_nxt;
  logic [4:0] dig_nxt;
  logic [7:0] vol_nxt;
  logic parallel_bridge_mode_nxt;
  logic [4:0] fsw_nxt;
  logic scl_nxt;
  logic sda_nxt;
  logic sw_mode_r;
  logic [8:0] ana_r;
  logic [4:0] dig_r;
  logic [7:0] vol_r;
  logic parallel_bridge_mode_r;
  logic [4:0] fsw_r;
  logic scl_r;
  logic sda_r;

  assign sw_mode = valid_r && (gain_r == `GSD_CODE_SW);

  always_comb
  begin
    ana_nxt = `GSD_ANA_LOW;
    dig_nxt = `GSD_BOOST_DB;
    vol_nxt = `GSD_VOL_RESET;
    parallel_bridge_mode_nxt = bridge_r;
    fsw_nxt = freq_r ? `GSD_FSW_HIGH_MULT : `GSD_FSW_LOW_MULT;
    scl_nxt = 1'b1;
    sda_nxt = 1'b1;
    if (sw_mode)
    begin
      ana_nxt = sw_analog_gain_in;
      dig_nxt = sw_boost_in;
      vol_nxt = sw_volume_in;
      parallel_bridge_mode_nxt = sw_parallel_bridge_in;
      fsw_nxt = sw_fsw_mult_in;
      scl_nxt = strap_sync[1];
      sda_nxt = strap_sync[0];
    end
    else
    begin
      case (gain_r)
        `GSD_CODE_LOW: ana_nxt = `GSD_ANA_LOW;
        `GSD_CODE_MID: ana_nxt = `GSD_ANA_MID;
        `GSD_CODE_HIGH: ana_nxt = `GSD_ANA_HIGH;
        default: ana_nxt = `GSD_ANA_LOW;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sw_mode_r <= 1'b0;
      ana_r <= `GSD_ANA_LOW;
      dig_r <= `GSD_BOOST_DB;
      vol_r <= `GSD_VOL_RESET;
      parallel_bridge_mode_r <= 1'b0;
      fsw_r <= `GSD_FSW_LOW_MULT;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      sw_mode_r <= sw_mode;
      ana_r <= ana_nxt;
      dig_r <= dig_nxt;
      vol_r <= vol_nxt;
      parallel_bridge_mode_r <= parallel_bridge_mode_nxt;
      fsw_r <= fsw_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  assign ctrl_scl_out = scl_r;
  assign ctrl_sda_out = sda_r;
  assign sw_mode_out = sw_mode_r;
  assign config_valid_out = valid_r;
  assign gain_strap_out = gain_r;
  assign analog_path_gain_out = ana_r;
  assign digital_path_gain_out = dig_r;
  assign volume_out = vol_r;
  assign parallel_bridge_mode_out = parallel_bridge_mode_r;
  assign fsw_mult_out = fsw_r;
endmodule : gsd_decoder

// *** sim/gsd_strap_board.sv ***
// board strap model driving the four strap pins
`timescale 1ns/1ps
module gsd_strap_board (
  // strap choice {gain hi, gain lo, bridge, freq}
  input wire logic [3:0] code_in,
  // strap pins
  output logic gain_strap_hi_out,
  output logic gain_strap_lo_out,
  output logic bridge_out,
  output logic freq_out
);
  assign {gain_strap_hi_out, gain_strap_lo_out, bridge_out, freq_out} = code_in;
endmodule : gsd_strap_board

// *** sim/gsd_decoder_sva.sv ***
// assertions on the decoder ports
`timescale 1ns/1ps
module gsd_decoder_sva (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [8:0] sw_analog_gain_in,
  input wire logic ctrl_scl_out,
  input wire logic ctrl_sda_out,
  input wire logic sw_mode_out,
  input wire logic config_valid_out,
  input wire logic [1:0] gain_strap_out,
  input wire logic [8:0] analog_path_gain_out,
  input wire logic [4:0] digital_path_gain_out,
  input wire logic [7:0] volume_out
);
  logic set_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      set_r <= 1'b0;
    else
      set_r <= config_valid_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ana_low: assert property (set_r && gain_strap_out == 2'h0 |-> analog_path_gain_out == 9'h0c0)
    else $error("analog gain wrong for code 0");
  a_ana_mid: assert property (set_r && gain_strap_out == 2'h1 |-> analog_path_gain_out == 9'h0e2)
    else $error("analog gain wrong for code 1");
  a_ana_high: assert property (set_r && gain_strap_out == 2'h2 |-> analog_path_gain_out == 9'h0fa)
    else $error("analog gain wrong for code 2");
  a_boost_hw: assert property (set_r && !sw_mode_out |-> digital_path_gain_out == 5'h06)
    else $error("boost not 6 dB");
  a_vol_hw: assert property (!sw_mode_out |-> volume_out == 8'h00)
    else $error("volume not 0 dB");
  a_sw_code: assert property (set_r |-> sw_mode_out == (gain_strap_out == 2'h3))
    else $error("mode does not match code");
  a_sw_gain: assert property (set_r && sw_mode_out |-> analog_path_gain_out == $past(sw_analog_gain_in))
    else $error("software analog gain not used");
  a_latch_hold: assert property (config_valid_out |=> config_valid_out && $stable(gain_strap_out))
    else $error("latched code moved");
  a_pins_idle: assert property (!sw_mode_out |-> ctrl_scl_out && ctrl_sda_out)
    else $error("control pins not idle");
endmodule : gsd_decoder_sva
bind gsd_decoder gsd_decoder_sva i_gsd_decoder_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .sw_analog_gain_in(sw_analog_gain_in), .ctrl_scl_out(ctrl_scl_out), .ctrl_sda_out(ctrl_sda_out),
  .sw_mode_out(sw_mode_out), .config_valid_out(config_valid_out), .gain_strap_out(gain_strap_out),
  .analog_path_gain_out(analog_path_gain_out), .digital_path_gain_out(digital_path_gain_out),
  .volume_out(volume_out));

// *** sim/gsd_decoder_tb.sv ***
// bench for the gain strap decoder
`timescale 1ns/1ps
module gsd_decoder_tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] code = 4'h0;
  logic [8:0] sw_ana = 9'h123;
  logic [7:0] sw_vol = 8'h5a;
  logic [4:0] sw_dig = 5'h0c;
  logic hi, lo, br, fq, scl, sda, swm, vld, pb;
  logic [1:0] gs;
  logic [8:0] ana;
  logic [4:0] dig, fsw;
  logic [7:0] vol;
  int n_mismatch = 0;
  int total_checks = 0;
  int i;
  always #10 sys_clk_in = ~sys_clk_in;
  gsd_strap_board i_gsd_strap_board (.code_in(code), .gain_strap_hi_out(hi), .gain_strap_lo_out(lo),
    .bridge_out(br), .freq_out(fq));
  gsd_decoder i_gsd_decoder (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .gain_strap_hi_in(hi),
    .gain_strap_lo_in(lo), .bridge_mode_clock_pin_in(br), .switch_freq_data_pin_in(fq),
    .sw_analog_gain_in(sw_ana), .sw_boost_in(sw_dig), .sw_volume_in(sw_vol), .sw_parallel_bridge_in(1'b1),
    .sw_fsw_mult_in(5'h04), .ctrl_scl_out(scl), .ctrl_sda_out(sda), .sw_mode_out(swm),
    .config_valid_out(vld), .gain_strap_out(gs), .analog_path_gain_out(ana), .digital_path_gain_out(dig),
    .volume_out(vol), .parallel_bridge_mode_out(pb), .fsw_mult_out(fsw));
  task stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task boot(input logic [3:0] c);
    int k;
    rst_n_in = 1'b0;
    code = c;
    cyc(6);
    chk(9'(vol), 9'h000);
    chk(9'(vld), 9'h000);
    rst_n_in = 1'b1;
    for (k = 0; k < 20 && vld !== 1'b1; k++)
      cyc(1);
    if (vld !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, vld, 1'b1);
      stop_test();
    end
    cyc(2);
  endtask : boot
  initial
  begin
    for (i = 0; i < 16; i++)
    begin
      boot(i[3:0]);
      chk(9'(gs), 9'(i[3:2]));
      chk(9'(swm), 9'(i[3:2] == 2'h3));
      if (i[3:2] == 2'h3)
      begin
        chk(ana, sw_ana);
        chk(9'(dig), 9'(sw_dig));
        chk(9'(pb), 9'h001);
        chk(9'(fsw), 9'h004);
        code = {2'h3, ~i[1:0]};
        cyc(4);
        chk(9'({scl, sda}), {7'h00, ~i[1:0]});
        sw_vol = sw_vol + 8'h11;
        sw_ana = sw_ana + 9'h011;
        sw_dig = sw_dig + 5'h03;
        cyc(2);
        chk(9'(vol), 9'(sw_vol));
        chk(ana, sw_ana);
        chk(9'(dig), 9'(sw_dig));
      end
      else
      begin
        chk(ana, i[3:2] == 2'h0 ? 9'h0c0 : i[3:2] == 2'h1 ? 9'h0e2 : 9'h0fa);
        chk(9'(dig), 9'h006);
        chk(9'(vol), 9'h000);
        chk(9'(pb), 9'(i[1]));
        chk(9'(fsw), i[0] ? 9'h008 : 9'h010);
        chk(9'({scl, sda}), 9'h003);
        code = ~i[3:0];
        cyc(4);
        chk(9'(gs), 9'(i[3:2]));
        chk(9'({scl, sda}), 9'h003);
      end
    end
    stop_test();
  end
endmodule : gsd_decoder_tb
